// File: verification/hbc_config_header_chk.sv
// hbc_config_header_chk.sv: port checks of the config header block.
// assumes a bind onto hbc_config_header, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hbc_config_header_chk #(
  parameter [7:0] REVISION = 8'h5a
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pci_io_access,
  input wire logic        pci_mem_access,
  input wire logic [31:0] pci_addr,
  input wire logic        io_window_hit,
  input wire logic        mem_window_hit,
  input wire logic [7:0]  revision_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic rdok = avs_read && !avs_waitrequest;
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  rev_pin_a: assert property (revision_field == REVISION) else $error("revision pin");
  class_rd_a: assert property (rdok && avs_address == 8'h08 |-> avs_readdata == {24'h060000, REVISION})
    else $error("class word");
  hdr_zero_a: assert property (rdok && avs_address == 8'h0c |-> avs_readdata == 32'h0)
    else $error("header word");
  io_low_a: assert property (rdok && avs_address == 8'h10 |-> avs_readdata[15:0] == 16'h0001)
    else $error("io base low bits");
  mem_low_a: assert property (rdok && avs_address == 8'h14 |-> avs_readdata[15:0] == 16'h0)
    else $error("mem base low bits");
  io_hit_a: assert property (io_window_hit |-> pci_io_access && pci_addr[31:16] != 16'h0)
    else $error("io claim");
  mem_hit_a: assert property (mem_window_hit |-> pci_mem_access && pci_addr[31:16] != 16'h0)
    else $error("mem claim");
  cover property (io_window_hit);
  cover property (mem_window_hit);
  cover property (rdok && avs_address == 8'h10);
endmodule
`default_nettype wire

// File: verification/hbc_config_header_tb_top.sv
// hbc_config_header_tb_top.sv: register and window decode bench.
// assumes the design files and the model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module hbc_config_header_tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, rdat;
  logic [1:0]  rsp;
  wire logic [31:0] avs_readdata, pci_addr;
  wire logic [1:0]  avs_response;
  wire logic [7:0]  revision_field;
  wire logic avs_waitrequest, pci_io_access, pci_mem_access, io_window_hit, mem_window_hit;
  int n_fail = 0, samples_checked = 0;
  always #20 clk = ~clk;
  hbc_config_header dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .pci_io_access(pci_io_access),
    .pci_mem_access(pci_mem_access), .pci_addr(pci_addr), .io_window_hit(io_window_hit),
    .mem_window_hit(mem_window_hit), .revision_field(revision_field));
  hbc_pci_master_model pm_u (.clk(clk), .io_acc(pci_io_access), .mem_acc(pci_mem_access), .addr(pci_addr));
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    // request held until the rising edge that sees waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      end_sim();
    end
    rdat = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic hit(input logic [1:0] k, input logic [31:0] a, input logic [1:0] e);
    pm_u.drive(k, a);
    @(negedge clk);
    chk({30'h0, io_window_hit, mem_window_hit}, {30'h0, e});
    pm_u.release_bus();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    chk({24'h0, revision_field}, 32'h5a);
    acc(1'b1, 8'h08, 32'hffffffff);
    rd(8'h08, 32'h0600005a);
    acc(1'b1, 8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h1);
    acc(1'b1, 8'h10, 32'hfffffffe);
    rd(8'h10, 32'hffff0001);
    acc(1'b1, 8'h14, 32'hffffffff);
    rd(8'h14, 32'hffff0000);
    acc(1'b1, 8'h10, 32'h12340000);
    acc(1'b1, 8'h14, 32'habcd0000);
    hit(2'b10, 32'h1234abcd, 2'b00);
    hit(2'b01, 32'habcd0010, 2'b00);
    acc(1'b1, 8'h04, 32'h3);
    hit(2'b10, 32'h1234abcd, 2'b10);
    hit(2'b10, 32'h1235abcd, 2'b00);
    hit(2'b10, 32'habcd0000, 2'b00);
    hit(2'b01, 32'habcdfffc, 2'b01);
    hit(2'b01, 32'h12340000, 2'b00);
    acc(1'b1, 8'h04, 32'h2);
    hit(2'b10, 32'h1234abcd, 2'b00);
    hit(2'b01, 32'habcd0000, 2'b01);
    acc(1'b1, 8'h04, 32'h1);
    hit(2'b01, 32'habcd0000, 2'b00);
    acc(1'b1, 8'h10, 32'h0);
    hit(2'b10, 32'h0000abcd, 2'b00);
    rd(8'h40, 32'h0);
    chk({30'h0, rsp}, 32'h3);
    end_sim();
  end
endmodule
bind hbc_config_header hbc_config_header_chk #(.REVISION(REVISION)) chk_u (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pci_io_access(pci_io_access), .pci_mem_access(pci_mem_access),
  .pci_addr(pci_addr), .io_window_hit(io_window_hit), .mem_window_hit(mem_window_hit),
  .revision_field(revision_field));
`default_nettype wire

// File: verification/hbc_pci_master_model.sv
// hbc_pci_master_model.sv: far-side PCI master presenting accesses.
// assumes tasks called from the bench on clk.
`timescale 1ns/1ps
`default_nettype none
module hbc_pci_master_model (
  input  wire logic        clk,
  output var  logic        io_acc,
  output var  logic        mem_acc,
  output var  logic [31:0] addr
);
  initial begin
    io_acc = 1'b0;
    mem_acc = 1'b0;
    addr = 32'h0;
  end
  task automatic drive(input logic [1:0] k, input logic [31:0] a);
    @(posedge clk);
    io_acc <= k[1];
    mem_acc <= k[0];
    addr <= a;
  endtask
  // released bus shows the inverse, not the old address
  task automatic release_bus();
    @(posedge clk);
    io_acc <= 1'b0;
    mem_acc <= 1'b0;
    addr <= ~addr;
  endtask
endmodule
`default_nettype wire

// File: verilog/hbc_base_reg.v
// hbc_base_reg.v: writable upper half of one window base register.
// assumes write strobe and byte enables from the bus slave.
`timescale 1ns/1ps
`default_nettype none

`include "hbc_defines.vh"

module hbc_base_reg (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        wr,
  input  wire [3:0]  byteenable,
  input  wire [31:0] wdata,
  output wire [15:0] base
);

  reg [15:0] base_q;
  reg [15:0] base_d;

  always @* begin
    base_d = base_q;
    if (wr && byteenable[2]) begin
      base_d[7:0] = wdata[23:16];
    end
    if (wr && byteenable[3]) begin
      base_d[15:8] = wdata[31:24];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= `HBC_BASE_RESET;
    end else begin
      base_q <= base_d;
    end
  end

  assign base = base_q;

endmodule

`default_nettype wire

// File: verilog/hbc_config_header.v
// hbc_config_header.v: identification words, command enables and two
// interrupt controller window base registers of a host bridge header.
// assumes an Avalon-MM master on clk and decoded PCI target accesses.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

`include "hbc_defines.vh"

module hbc_config_header #(
  parameter [7:0] REVISION = 8'h5a  // arbitrary value
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire [1:0]  avs_response,
  input  wire        pci_io_access,
  input  wire        pci_mem_access,
  input  wire [31:0] pci_addr,
  output wire        io_window_hit,
  output wire        mem_window_hit,
  output wire [7:0]  revision_field
);

  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg  [1:0]  resp_q;
  reg  [1:0]  resp_d;
  reg  [1:0]  cmd_q;
  reg  [1:0]  cmd_d;
  wire [15:0] io_base;
  wire [15:0] mem_base;
  wire        take;
  wire        wr_take;
  wire        io_wr;
  wire        mem_wr;
  wire        mapped;

  // one wait cycle per access: taken in idle, answered in done
  assign take    = (state_q == ST_IDLE) && (avs_read || avs_write);
  assign wr_take = take && avs_write;
  assign io_wr   = wr_take && (avs_address == `HBC_OFF_IO_BASE);
  assign mem_wr  = wr_take && (avs_address == `HBC_OFF_MEM_BASE);

  assign mapped = (avs_address == `HBC_OFF_CMD) ||
                  (avs_address == `HBC_OFF_CLASS_REV) ||
                  (avs_address == `HBC_OFF_HEADER) ||
                  (avs_address == `HBC_OFF_IO_BASE) ||
                  (avs_address == `HBC_OFF_MEM_BASE);

  hbc_base_reg u_io_base (
    .clk        (clk),
    .reset_n    (reset_n),
    .wr         (io_wr),
    .byteenable (avs_byteenable),
    .wdata      (avs_writedata),
    .base       (io_base)
  );

  hbc_base_reg u_mem_base (
    .clk        (clk),
    .reset_n    (reset_n),
    .wr         (mem_wr),
    .byteenable (avs_byteenable),
    .wdata      (avs_writedata),
    .base       (mem_base)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @* begin
    cmd_d = cmd_q;
    if (wr_take && (avs_address == `HBC_OFF_CMD) && avs_byteenable[0]) begin
      cmd_d = {avs_writedata[`HBC_CMD_MEM_EN_BIT], avs_writedata[`HBC_CMD_IO_EN_BIT]};
    end
  end

  always @* begin
    rdata_d = rdata_q;
    resp_d  = resp_q;
    if (take) begin
      resp_d  = mapped ? 2'h0 : 2'h3;
      rdata_d = 32'h00000000;
      if (avs_read) begin
        case (avs_address)
          `HBC_OFF_CMD: begin
            rdata_d = {30'h00000000, cmd_q};
          end
          `HBC_OFF_CLASS_REV: begin
            rdata_d = {`HBC_CLASS_CODE, REVISION};
          end
          `HBC_OFF_HEADER: begin
            rdata_d = `HBC_HEADER_VALUE;
          end
          `HBC_OFF_IO_BASE: begin
            // low bits zero, reserved bit zero, io flag one
            rdata_d = {io_base, 14'h0000, 1'b0, `HBC_BAR_IO_FLAG};
          end
          `HBC_OFF_MEM_BASE: begin
            // prefetch, type and space flags all zero
            rdata_d = {mem_base, 12'h000, 1'b0, 2'h0, `HBC_BAR_MEM_FLAG};
          end
          default: begin
            rdata_d = 32'h00000000;
          end
        endcase
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      rdata_q <= 32'h00000000;
      resp_q  <= 2'h0;
      cmd_q   <= `HBC_CMD_RESET;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      resp_q  <= resp_d;
      cmd_q   <= cmd_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (state_q != ST_DONE);
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;
  assign revision_field  = REVISION;

  hbc_window_match u_io_match (
    .base     (io_base),
    .space_en (cmd_q[`HBC_CMD_IO_EN_BIT]),
    .access   (pci_io_access),
    .addr     (pci_addr),
    .hit      (io_window_hit)
  );

  hbc_window_match u_mem_match (
    .base     (mem_base),
    .space_en (cmd_q[`HBC_CMD_MEM_EN_BIT]),
    .access   (pci_mem_access),
    .addr     (pci_addr),
    .hit      (mem_window_hit)
  );

endmodule

`default_nettype wire

// File: verilog/hbc_defines.vh
// hbc_defines.vh: offsets, field positions and reset values of the
// host bridge configuration header block; definitions only.
`ifndef HBC_DEFINES_VH
`define HBC_DEFINES_VH

// register byte offsets
`define HBC_OFF_CLASS_REV      8'h08
`define HBC_OFF_HEADER         8'h0c
`define HBC_OFF_IO_BASE        8'h10
`define HBC_OFF_MEM_BASE       8'h14
`define HBC_OFF_CMD            8'h04

// fields
`define HBC_CLASS_CODE         24'h060000
`define HBC_HEADER_VALUE       32'h00000000
`define HBC_BASE_MSB           31
`define HBC_BASE_LSB           16
`define HBC_BAR_IO_FLAG        1'b1
`define HBC_BAR_MEM_FLAG       1'b0
`define HBC_CMD_IO_EN_BIT      0
`define HBC_CMD_MEM_EN_BIT     1

// reset values
`define HBC_BASE_RESET         16'h0000
`define HBC_CMD_RESET          2'h0

`endif

// File: verilog/hbc_window_match.v
// hbc_window_match.v: one 64 KB window decoder of the bridge.
// assumes base and address come from clk-domain registers.
`timescale 1ns/1ps
`default_nettype none

module hbc_window_match (
  input  wire [15:0] base,
  input  wire        space_en,
  input  wire        access,
  input  wire [31:0] addr,
  output wire        hit
);

  // base of zero disables the decoder
  assign hit = access && space_en && (base != 16'h0000) && (addr[31:16] == base);

endmodule

`default_nettype wire
